// ---- pcs_pkg.sv ----
package pcs_pkg;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_STAT = 8'h04;
  localparam logic [7:0]  ADDR_MASK = 8'h08;
  localparam logic [7:0]  ADDR_INFO = 8'h0C;

  // Control register layout and reset value
  localparam logic [15:0] CTRL_RESET = 16'h3F00;
  localparam int          W_BIT      = 15;
  localparam int          X_BIT      = 14;
  localparam int          Y_HI       = 13;
  localparam int          Y_LO       = 8;
  localparam int          LOCK_BIT   = 3;

  // Event status bits, mask uses the same layout
  localparam int          EV_LOCKED  = 0;
  localparam int          EV_UNLOCK  = 1;
  localparam int          EV_WIDTH   = 2;

  // Info register bits
  localparam int          INFO_PLL   = 0;
  localparam int          INFO_RUN   = 1;

  // Lock model timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          LOCK_TIME_NS  = 5000;
  localparam int          LOCK_CYC_I    = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] LOCK_CYCLES   = LOCK_CYC_I[15:0];

  // Feedback divider terminal counts
  localparam logic [2:0]  PRE_TC_SLOW = 3'h1;
  localparam logic [2:0]  PRE_TC_FAST = 3'h7;
  localparam logic [2:0]  POST_TC     = 3'h7;

  // Lock state machine
  typedef enum logic [1:0] {
    LK_STRAP  = 2'b00,
    LK_ACQ    = 2'b01,
    LK_LOCKED = 2'b10,
    LK_BYPASS = 2'b11
  } pcs_lock_st_t;

  // Clock multiplier 4(Y+1) * 2^(2W+X)
  function automatic logic [12:0] pcs_mult(input logic w, input logic x, input logic [5:0] y);
    logic [12:0] m;
    m = ({7'h00, y} + 13'h0001) << 2;
    return m << {w, x};
  endfunction : pcs_mult

endpackage : pcs_pkg

// ---- pcs_synth_ctrl.sv ----
// Notes on behaviour
// - VCO runs at two or four times system clock, chosen by bypass bit.
// - VCO speed bit switches a three-bit feedback prescaler, raising VCO fourfold.
// - Modulus field loads a modulo-64 down counter dividing feedback by field plus one.
// - Changing speed bit or modulus starts a relock before lock is shown again.
// - Bypass bit clear at reset keeps extra divide-by-two, clock is VCO quarter.
// - Changing only the bypass bit changes clock at once, no relock.
// - System clock equals reference times 4(Y+1) times 2 to the (2W+X).
// - Control register resets to 3F00 hex.
// - Lock flag in control register, clear while reacquiring lock.
// - Internal reset held until the synthesizer first reports lock; with strap low, freed after the strap.
// - Any comparator input change drops lock and forces relock.
// - Strap low at reset disables the PLL; reference pin is the clock.
// - Strap high enables register control; strap low makes control bits inert.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module pcs_synth_ctrl (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire  logic        reference_clock_input,
  input  wire  logic        clock_source_strap,
  output logic              sys_clk_out,
  output logic              fb_tick,
  output logic              internal_rst_n,
  output logic [12:0]       sys_mult,
  output logic [12:0]       vco_mult,
  output logic              irq
);
  import pcs_pkg::*;

  // Control fields
  logic                  speed_r;
  logic                  bypass_r;
  logic [5:0]            modulus_r;

  // Interrupt status and mask, same bit layout
  logic [EV_WIDTH-1:0]   stat_r;
  logic [EV_WIDTH-1:0]   mask_r;

  // Read data held for the data phase
  logic [31:0]           rdata_r;

  // Bus data-phase state
  logic                  wr_pend_r;
  logic [7:0]            wr_addr_r;

  // Strap, lock and reset state
  logic                  pll_en_r;
  pcs_lock_st_t          lk_st_r;
  pcs_lock_st_t          lk_st_nxt;
  logic [15:0]           lk_cnt_r;
  logic                  run_r;

  // Reference period watcher
  logic                  ref_q_r;
  logic                  ref_seen_r;
  logic [15:0]           ref_cnt_r;
  logic [15:0]           ref_per_r;
  logic                  ref_per_ok_r;

  // Feedback divider and clock output model
  logic [2:0]            pre_cnt_r;
  logic [5:0]            mod_cnt_r;
  logic [2:0]            post_cnt_r;

  // System clock model and multiplier readouts
  logic                  half_r;
  logic                  fb_r;
  logic                  clk_r;
  logic [12:0]           sys_mult_r;
  logic [12:0]           vco_mult_r;

  // Address decode of the accepted address phase
  wire                   addr_ok   = hsel & hready & htrans[1];
  wire                   rd_acc    = addr_ok & ~hwrite;
  wire                   wr_acc    = addr_ok & hwrite;
  wire [7:0]             a_lo      = haddr[7:0];
  wire                   in_range  = (haddr[31:8] == 24'h000000);

  // Register selects; anything unmapped reads as zero
  wire                   sel_ctrl  = in_range & (a_lo == ADDR_CTRL);
  wire                   sel_stat  = in_range & (a_lo == ADDR_STAT);
  wire                   sel_mask  = in_range & (a_lo == ADDR_MASK);
  wire                   sel_info  = in_range & (a_lo == ADDR_INFO);

  // Data-phase write strobes and the read-clear of the status
  wire                   wr_ctrl   = wr_pend_r & (wr_addr_r == ADDR_CTRL);
  wire                   wr_mask   = wr_pend_r & (wr_addr_r == ADDR_MASK);
  wire                   rd_clr    = rd_acc & sel_stat;

  // Values written by the pending data phase
  wire                   new_speed = hwdata[W_BIT];
  wire                   new_bypass= hwdata[X_BIT];
  wire [5:0]             new_mod   = hwdata[Y_HI:Y_LO];
  wire                   loop_chg  = wr_ctrl & ((new_speed != speed_r) | (new_mod != modulus_r));

  // Lock flag is clear outside the locked state
  wire                   locked    = (lk_st_r == LK_LOCKED);

  // Reference edge; the first period after reset is partial, so it is not compared
  wire                   ref_rise  = reference_clock_input & ~ref_q_r;
  wire                   ref_chg   = ref_rise & ref_per_ok_r & (ref_cnt_r != ref_per_r);
  wire                   relock    = pll_en_r & (loop_chg | ref_chg);

  // Events for the sticky status register
  wire                   ev_locked = (lk_st_r == LK_ACQ) & (lk_cnt_r == 16'h0000) & ~relock;
  wire                   ev_unlock = locked & relock;
  wire [EV_WIDTH-1:0]    ev_set    = {ev_unlock, ev_locked};

  // Read mux for the control register and the others
  wire [15:0]            ctrl_view = {speed_r, bypass_r, modulus_r, 4'h0, locked, 3'h0};
  wire [31:0]            rd_mux    = sel_ctrl ? {16'h0000, ctrl_view} :
                                     sel_stat ? {30'h0, stat_r} :
                                     sel_mask ? {30'h0, mask_r} :
                                     sel_info ? {30'h0, run_r, pll_en_r} : 32'h0000_0000;

  // Feedback divider terminal counts
  // prescaler ratio
  wire [2:0]             pre_tc    = speed_r ? PRE_TC_FAST : PRE_TC_SLOW;
  wire                   pre_wrap  = (pre_cnt_r == pre_tc);
  wire                   mod_wrap  = pre_wrap & (mod_cnt_r == 6'h00);
  wire                   post_wrap = mod_wrap & (post_cnt_r == POST_TC);

  // multiplier for system clock and VCO
  wire [12:0]            sys_m     = pcs_mult(speed_r, bypass_r, modulus_r);
  wire [12:0]            vco_m     = pcs_mult(speed_r, 1'b0, modulus_r) << 2;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // Clock, reset and multiplier outputs come straight from flip-flops
  assign sys_clk_out = clk_r;
  assign fb_tick   = fb_r;
  assign internal_rst_n = run_r;
  assign sys_mult  = sys_mult_r;
  assign vco_mult  = vco_mult_r;

  // Level interrupt; stays high until software reads the status
  assign irq       = |(stat_r & mask_r);

  // Address phase capture; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_acc & in_range;
      wr_addr_r <= a_lo;
      if (rd_acc) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Control fields, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_r   <= CTRL_RESET[W_BIT];
      bypass_r  <= CTRL_RESET[X_BIT];
      modulus_r <= CTRL_RESET[Y_HI:Y_LO];
    end else if (wr_ctrl) begin
      speed_r   <= new_speed;
      bypass_r  <= new_bypass;
      modulus_r <= new_mod;
    end
  end

  // Mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= hwdata[EV_WIDTH-1:0];
    end
  end

  // Sticky status: read clears, a new event in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (rd_clr ? '0 : stat_r) | ev_set;
    end
  end

  // Strap is caught once, on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_en_r <= 1'b0;
    end else if (lk_st_r == LK_STRAP) begin
      pll_en_r <= clock_source_strap;
    end
  end

  // Lock state machine next state
  always_comb begin
    lk_st_nxt = lk_st_r;
    case (lk_st_r)
      LK_STRAP: begin
        lk_st_nxt = clock_source_strap ? LK_ACQ : LK_BYPASS;
      end
      LK_ACQ: begin
        if (ev_locked) begin
          lk_st_nxt = LK_LOCKED;
        end
      end
      LK_LOCKED: begin
        if (relock) begin
          lk_st_nxt = LK_ACQ;
        end
      end
      default: begin
        lk_st_nxt = LK_BYPASS;
      end
    endcase
  end

  // Lock state and modelled acquisition time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_st_r  <= LK_STRAP;
      lk_cnt_r <= LOCK_CYCLES;
    end else begin
      lk_st_r <= lk_st_nxt;
      if (relock || lk_st_r == LK_STRAP) begin
        lk_cnt_r <= LOCK_CYCLES;
      end else if (lk_st_r == LK_ACQ && lk_cnt_r != 16'h0000) begin
        lk_cnt_r <= lk_cnt_r - 16'h0001;
      end
    end
  end

  // Internal reset: held until first lock; with PLL off, freed after the strap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
    end else if (lk_st_r == LK_LOCKED || lk_st_r == LK_BYPASS) begin
      run_r <= 1'b1;
    end
  end

  // Reference period in hclk cycles; a differing period means a new input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q_r    <= 1'b0;
      ref_seen_r <= 1'b0;
      ref_cnt_r  <= 16'h0000;
      ref_per_r  <= 16'h0000;
      ref_per_ok_r <= 1'b0;
    end else begin
      ref_q_r <= reference_clock_input;
      if (ref_rise) begin
        ref_per_r  <= ref_cnt_r;
        ref_seen_r <= 1'b1;
        ref_per_ok_r <= ref_seen_r;
        ref_cnt_r  <= 16'h0001;
      end else if (ref_cnt_r != 16'hFFFF) begin
        ref_cnt_r  <= ref_cnt_r + 16'h0001;
      end
    end
  end

  // Feedback chain: VCO tick each hclk, prescaler, modulo-64 counter, fixed /8
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r  <= 3'h0;
      mod_cnt_r  <= CTRL_RESET[Y_HI:Y_LO];
      post_cnt_r <= 3'h0;
      fb_r       <= 1'b0;
    end else if (!pll_en_r) begin
      pre_cnt_r  <= 3'h0;
      mod_cnt_r  <= modulus_r;
      post_cnt_r <= 3'h0;
      fb_r       <= 1'b0;
    end else begin
      pre_cnt_r <= pre_wrap ? 3'h0 : pre_cnt_r + 3'h1;
      if (pre_wrap) begin
        mod_cnt_r <= (mod_cnt_r == 6'h00) ? modulus_r : mod_cnt_r - 6'h01;
      end
      if (mod_wrap) begin
        post_cnt_r <= post_cnt_r + 3'h1;
      end
      fb_r <= post_wrap;
    end
  end

  // System clock: toggles on VCO ticks, every second tick while bypass is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_r <= 1'b0;
      clk_r  <= 1'b0;
    end else if (!pll_en_r) begin
      half_r <= 1'b0;
      clk_r  <= reference_clock_input;
    end else begin
      half_r <= ~half_r;
      // VCO two or four times clock
      if (bypass_r || half_r) begin
        clk_r <= ~clk_r;
      end
    end
  end

  // Multiplier readouts; zero while the synthesizer is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_mult_r <= 13'h0000;
      vco_mult_r <= 13'h0000;
    end else begin
      sys_mult_r <= pll_en_r ? sys_m : 13'h0000;
      vco_mult_r <= pll_en_r ? vco_m : 13'h0000;
    end
  end

endmodule : pcs_synth_ctrl

// ---- pcs_ref_src.sv ----
`timescale 1ns/1ns
module pcs_ref_src (
  input  wire logic       hclk,
  input  wire logic [3:0] half_cyc,
  output logic            ref_out
);
  logic [3:0] cnt_r = 4'h0;
  logic       wrap;
  initial ref_out = 1'b0;
  assign wrap = (cnt_r + 4'h1) >= half_cyc;
  // reference drive
  // Locked to hclk so edge spacing is exact; a new half period reads as a new input
  always @(posedge hclk) begin
    cnt_r <= wrap ? 4'h0 : cnt_r + 4'h1;
    if (wrap) ref_out <= ~ref_out;
  end
endmodule : pcs_ref_src

// ---- pcs_synth_chk.sv ----
`timescale 1ns/1ns
module pcs_synth_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        reference_clock_input,
  input wire logic        sys_clk_out,
  input wire logic        fb_tick,
  input wire logic        internal_rst_n,
  input wire logic [12:0] sys_mult,
  input wire logic [12:0] vco_mult
);
  // VCO to system ratio of four or two tells the bypass state
  wire         on = sys_mult != 13'h0000;
  wire         x0 = on && ({2'h0, vco_mult} == {sys_mult, 2'h0});
  wire         x1 = on && ({1'h0, vco_mult} == {sys_mult, 1'h0});
  logic [13:0] gap_r;
  logic        seen_r;
  logic [12:0] vmul_r;
  // Tick spacing, forgotten whenever the multiplier moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r  <= 14'h0000;
      seen_r <= 1'b0;
      vmul_r <= 13'h0000;
    end else begin
      gap_r  <= fb_tick ? 14'h0000 : gap_r + 14'h0001;
      seen_r <= (vco_mult == vmul_r) & (seen_r | fb_tick);
      vmul_r <= vco_mult;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_low2;
    !sys_clk_out ##1 !sys_clk_out;
  endsequence
  AST_VCO_RATIO: assert property (on |-> x0 || x1)
    else $error("vco to system ratio wrong");
  AST_CLK_QUARTER: assert property (disable iff (!hresetn || !x0)
    $rose(sys_clk_out) && $past(x0, 2) |=> sys_clk_out ##1 s_low2 ##1 sys_clk_out)
    else $error("system clock not four cycles");
  AST_CLK_HALF: assert property (disable iff (!hresetn || !x1)
    $rose(sys_clk_out) && $past(x1) |=> !sys_clk_out ##1 sys_clk_out)
    else $error("system clock not two cycles");
  AST_FB_PULSE: assert property (fb_tick |=> !fb_tick [*8])
    else $error("feedback tick too long");
  AST_FB_PERIOD: assert property (fb_tick && seen_r |-> gap_r == {1'b0, vco_mult} - 14'h0001)
    else $error("feedback period wrong");
  AST_RST_HOLD: assert property (internal_rst_n |=> internal_rst_n)
    else $error("internal reset fell again");
  AST_EXT_CLK: assert property (internal_rst_n && !on |-> sys_clk_out == $past(reference_clock_input))
    else $error("external clock not passed");
  AST_STRAP_INERT: assert property (internal_rst_n && !on |=> !on && vco_mult == 13'h0000)
    else $error("control active with pll off");
endmodule : pcs_synth_chk

bind pcs_synth_ctrl pcs_synth_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .reference_clock_input(reference_clock_input), .sys_clk_out(sys_clk_out),
  .fb_tick(fb_tick), .internal_rst_n(internal_rst_n), .sys_mult(sys_mult), .vco_mult(vco_mult));

// ---- test_pll_clock_synthesizer_control.sv ----
`timescale 1ns/1ns
module test_pll_clock_synthesizer_control;
  import pcs_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        strap = 1'b1;
  logic [3:0]  half_cyc = 4'h3;
  wire         hreadyout, hresp, ref_clk, sys_clk, fb, rst_n, irq;
  wire [31:0]  hrdata;
  wire [12:0]  smul, vmul;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [31:0] rd;
  pcs_ref_src src (.hclk(hclk), .half_cyc(half_cyc), .ref_out(ref_clk));
  pcs_synth_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reference_clock_input(ref_clk),
    .clock_source_strap(strap), .sys_clk_out(sys_clk), .fb_tick(fb),
    .internal_rst_n(rst_n), .sys_mult(smul), .vco_mult(vmul), .irq(irq));
  always #5 hclk = ~hclk;
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One AHB single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  task automatic wait_lock(input logic want);
    for (int i = 0; i < 800; i++) begin
      bus(1'b0, ADDR_CTRL, 32'h0);
      if (rd[LOCK_BIT] === want) break;
    end
  endtask : wait_lock
  task automatic do_reset(input logic s);
    hresetn <= 1'b0;
    strap <= s;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  // Main sequence
  initial begin
    do_reset(1'b1);
    rdc(ADDR_CTRL, 32'h3F00);
    rdc(ADDR_MASK, 32'h0);
    rdc(8'h40, 32'h0);
    check({31'h0, rst_n}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    wait_lock(1'b1);
    check(rd, 32'h3F08);
    repeat (2) @(posedge hclk);
    check({31'h0, rst_n}, 32'h1);
    rdc(ADDR_STAT, 32'h1);
    rdc(ADDR_STAT, 32'h0);
    check({19'h0, smul}, 32'h100);
    check({19'h0, vmul}, 32'h400);
    $display("test power-up lock done");
    bus(1'b1, ADDR_MASK, 32'h3);
    rdc(ADDR_MASK, 32'h3);
    bus(1'b1, ADDR_CTRL, 32'h7F08);
    rdc(ADDR_CTRL, 32'h7F08);
    check({19'h0, smul}, 32'h200);
    check({31'h0, irq}, 32'h0);
    $display("test bypass done");
    bus(1'b1, ADDR_CTRL, 32'h8700);
    rdc(ADDR_CTRL, 32'h8700);
    check({31'h0, irq}, 32'h1);
    rdc(ADDR_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    check({19'h0, smul}, 32'h80);
    check({19'h0, vmul}, 32'h200);
    wait_lock(1'b1);
    check(rd, 32'h8708);
    repeat (2100) @(posedge hclk);
    $display("test relock on write done");
    half_cyc <= 4'h5;
    wait_lock(1'b0);
    check({31'h0, rd[LOCK_BIT]}, 32'h0);
    wait_lock(1'b1);
    check(rd, 32'h8708);
    $display("test reference change done");
    do_reset(1'b0);
    repeat (3) @(posedge hclk);
    rdc(ADDR_INFO, 32'h2);
    bus(1'b1, ADDR_CTRL, 32'hC108);
    repeat (600) @(posedge hclk);
    rdc(ADDR_CTRL, 32'hC100);
    check({19'h0, smul}, 32'h0);
    $display("test external clock done");
    results();
  end
endmodule : test_pll_clock_synthesizer_control
